// ### bench/hvmsc_pin_env.sv
// Pin environment: stiff sense source and pull-set level on the shared pin
`default_nettype none
module hvmsc_pin_env (
  // Design pin side
  input  wire logic                   pin_o,
  input  wire logic                   pin_oe,
  input  wire logic                   switch_closed,
  input  wire hvmsc_pkg::hvmsc_pull_t pin_pull,
  // Stimulus from the bench
  input  wire logic                   sense_src,
  // Levels seen by the design
  output var  logic                   hv_sense_input,
  output var  logic                   pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // The sense source is low impedance, so it always wins at its pin
  assign hv_sense_input = sense_src;

  // Design drive wins; a closed switch passes the sense level; otherwise the pin follows the pull-up setting
  always_comb
  begin
    if (pin_oe)
      pin_level = pin_o;
    else if (switch_closed)
      pin_level = sense_src;
    else
      pin_level = pin_pull.up;
  end
endmodule // hvmsc_pin_env
`default_nettype wire

// ### bench/test_hv_measurement_switch_control.sv
// Self-checking bench of the measurement switch control
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module test_hv_measurement_switch_control;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
  } hvmsc_row_t;

  // Bus, control and pin signals
  logic                   pclk, presetn, psel, penable, pwrite;
  logic                   pready, pslverr, err, irq;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rd;
  logic                   fail_safe_req, other_wake_src, fail_event;
  logic [2:0]             op_mode_code;
  logic                   hv_sense_input, pin_i, pin_o, pin_oe, sw;
  logic                   sense_src, sense_to_logic, pin_to_logic;
  logic                   sense_wake_src_en;
  hvmsc_pkg::hvmsc_pull_t sense_pull, pin_pull;
  int                     n_mismatch = 0;
  int                     cmp_count = 0;

  // Ordinary cases: reads carry the expected word in data
  localparam hvmsc_row_t ROWS [16] = '{
    '{1'b0, hvmsc_pkg::ADDR_PIN, 32'h0},
    '{1'b0, hvmsc_pkg::ADDR_MODE, 32'h0},
    '{1'b0, hvmsc_pkg::ADDR_CTRL, 32'h0},
    '{1'b1, hvmsc_pkg::ADDR_PULL, 32'h5},
    '{1'b0, hvmsc_pkg::ADDR_PULL, 32'h5},
    '{1'b1, hvmsc_pkg::ADDR_MODE, 32'h1},
    '{1'b0, hvmsc_pkg::ADDR_MODE, 32'h1},
    '{1'b1, hvmsc_pkg::ADDR_PIN, 32'h1},
    '{1'b1, hvmsc_pkg::ADDR_CTRL, 32'h1},
    '{1'b0, hvmsc_pkg::ADDR_CTRL, 32'h0},
    '{1'b0, hvmsc_pkg::ADDR_STATUS, 32'h1},
    '{1'b1, hvmsc_pkg::ADDR_STATUS, 32'h1},
    '{1'b0, hvmsc_pkg::ADDR_STATUS, 32'h0},
    '{1'b1, hvmsc_pkg::ADDR_PIN, 32'h0},
    '{1'b1, hvmsc_pkg::ADDR_CTRL, 32'h1},
    '{1'b0, hvmsc_pkg::ADDR_CTRL, 32'h1}
  };

  hvmsc_top i_hvmsc_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fail_safe_req, .other_wake_src,
    .fail_event, .op_mode_code, .irq, .hv_sense_input,
    .fail_or_io_pin_i(pin_i), .fail_or_io_pin_o(pin_o),
    .fail_or_io_pin_oe(pin_oe), .meas_switch_closed(sw),
    .sense_pull, .pin_pull, .sense_to_logic, .pin_to_logic,
    .sense_wake_src_en
  );

  hvmsc_pin_env i_hvmsc_pin_env (
    .pin_o, .pin_oe, .switch_closed(sw), .pin_pull, .sense_src,
    .hv_sense_input, .pin_level(pin_i)
  );

  // Free-running bus clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic stop_test;
    $display("Mismatches %0d, compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Registered outputs lag the register write by a cycle or two
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic fs_pulse;
    @(posedge pclk);
    fail_safe_req <= 1'b1;
    @(posedge pclk);
    fail_safe_req <= 1'b0;
    settle();
  endtask

  // Hang guard, well beyond the few hundred cycles the run needs
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fail_safe_req = 1'b0;
    other_wake_src = 1'b0;
    fail_event = 1'b0;
    sense_src = 1'b0;
    repeat (10) @(posedge pclk);
    `CHK(sw, 1'b0)
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      apb(ROWS[i].wr, ROWS[i].addr, ROWS[i].data);
      if (!ROWS[i].wr)
        `CHK(rd, ROWS[i].data)
    end
    // Measuring in normal mode: switch closed, pins cut off
    sense_src <= 1'b1;
    settle();
    `CHK(sw, 1'b1)
    `CHK(sense_pull, 2'h0)
    `CHK(pin_pull, 2'h0)
    `CHK(sense_to_logic, 1'b0)
    `CHK(pin_to_logic, 1'b0)
    rdc(hvmsc_pkg::ADDR_LEVEL, 32'h0);
    rdc(hvmsc_pkg::ADDR_STATUS, 32'h0);
    apb(1'b1, hvmsc_pkg::ADDR_PULL, 32'hF);
    rdc(hvmsc_pkg::ADDR_PULL, 32'hF);
    apb(1'b1, hvmsc_pkg::ADDR_WAKE, 32'h1);
    rdc(hvmsc_pkg::ADDR_WAKE, 32'h1);
    settle();
    `CHK(pin_pull, 2'h0)
    `CHK(sense_wake_src_en, 1'b0)
    // Pin function write while measuring; interrupt masked first
    fail_event <= 1'b1;
    apb(1'b1, hvmsc_pkg::ADDR_PIN, 32'hB);
    rdc(hvmsc_pkg::ADDR_STATUS, 32'h1);
    settle();
    `CHK(pin_oe, 1'b0)
    `CHK(irq, 1'b0)
    apb(1'b1, hvmsc_pkg::ADDR_MASK, 32'h7);
    settle();
    `CHK(irq, 1'b1)
    apb(1'b1, hvmsc_pkg::ADDR_PIN, 32'h0);
    apb(1'b1, hvmsc_pkg::ADDR_STATUS, 32'h7);
    settle();
    `CHK(irq, 1'b0)
    // Leaving normal mode opens the switch on the very write edge
    apb(1'b1, hvmsc_pkg::ADDR_MODE, 32'h2);
    #1;
    `CHK(sw, 1'b0)
    `CHK(op_mode_code, hvmsc_pkg::MC_STOP)
    repeat (4)
    begin
      @(posedge pclk);
      #1;
      `CHK(sw, 1'b0)
    end
    `CHK(op_mode_code, hvmsc_pkg::MC_STOP)
    rdc(hvmsc_pkg::ADDR_CTRL, 32'h1);
    // Sleep with only sense wake while measuring
    apb(1'b1, hvmsc_pkg::ADDR_MODE, 32'h1);
    apb(1'b1, hvmsc_pkg::ADDR_MODE, 32'h3);
    settle();
    `CHK(op_mode_code, hvmsc_pkg::MC_RESTART)
    rdc(hvmsc_pkg::ADDR_STATUS, 32'h1);
    // Another wake source lets the sleep command through
    other_wake_src <= 1'b1;
    apb(1'b1, hvmsc_pkg::ADDR_MODE, 32'h3);
    settle();
    `CHK(op_mode_code, hvmsc_pkg::MC_SLEEP)
    `CHK(sw, 1'b0)
    other_wake_src <= 1'b0;
    // Fail-safe with and without measurement
    fs_pulse();
    `CHK(op_mode_code, hvmsc_pkg::MC_FAILSAFE)
    `CHK(sw, 1'b0)
    `CHK(sense_wake_src_en, 1'b0)
    rdc(hvmsc_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, hvmsc_pkg::ADDR_MODE, 32'h1);
    apb(1'b1, hvmsc_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, hvmsc_pkg::ADDR_WAKE, 32'h0);
    fs_pulse();
    `CHK(sense_wake_src_en, 1'b1)
    rdc(hvmsc_pkg::ADDR_WAKE, 32'h1);
    // Level and wake flags track the pins again once measuring stops
    rdc(hvmsc_pkg::ADDR_LEVEL, 32'h3);
    rdc(hvmsc_pkg::ADDR_STATUS, 32'h3);
    // Fail output works again once measurement is off
    apb(1'b1, hvmsc_pkg::ADDR_PIN, 32'h1);
    settle();
    `CHK(pin_oe, 1'b1)
    `CHK(pin_o, 1'b0)
    apb(1'b0, 8'h20, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    // Reset in mid-measurement opens the switch at once
    apb(1'b1, hvmsc_pkg::ADDR_MODE, 32'h1);
    apb(1'b1, hvmsc_pkg::ADDR_PIN, 32'h0);
    apb(1'b1, hvmsc_pkg::ADDR_CTRL, 32'h1);
    settle();
    `CHK(sw, 1'b1)
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK(sw, 1'b0)
    `CHK(pin_oe, 1'b0)
    @(posedge pclk);
    presetn <= 1'b1;
    rdc(hvmsc_pkg::ADDR_CTRL, 32'h0);
    stop_test();
  end
endmodule // test_hv_measurement_switch_control
`default_nettype wire

// ### logic/hvmsc_pkg.sv
// Constants, register map and types of the measurement switch control
`default_nettype none
// Behaviour
// - Reset leaves measurement off, switch open
// - Switch closes only in normal mode
// - Measuring cuts pulls and gates pin inputs
// - Pin settings stored but not applied
// - Level and wake flags frozen while measuring
// - Sleep while measuring with only sense or pin wake: error, restart
// - Fail output, GPIO, pin wake unavailable
// - Pin function write while measuring: error
// - Enable refused unless pin is off
// - Fail-safe: keep config, else auto sense wake
package hvmsc_pkg;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MODE   = 8'h04;
  localparam logic [7:0] ADDR_PIN    = 8'h08;
  localparam logic [7:0] ADDR_PULL   = 8'h0C;
  localparam logic [7:0] ADDR_WAKE   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_MASK   = 8'h18;
  localparam logic [7:0] ADDR_LEVEL  = 8'h1C;

  // Field positions
  localparam int CTRL_MEAS      = 0;
  localparam int MODE_LSB       = 0;
  localparam int PIN_FUNC_LSB   = 0;
  localparam int PIN_TEST       = 2;
  localparam int PIN_LEVEL      = 3;
  localparam int PULL_SENSE_LSB = 0;
  localparam int PULL_PIN_LSB   = 2;
  localparam int WAKE_SENSE     = 0;
  localparam int ST_CMD_ERR     = 0;
  localparam int ST_WAKE_SENSE  = 1;
  localparam int ST_WAKE_PIN    = 2;
  localparam int ST_W           = 3;
  localparam int LVL_SENSE      = 0;
  localparam int LVL_PIN        = 1;

  // Operating mode codes, as written and read back
  localparam logic [2:0] MC_INIT     = 3'h0;
  localparam logic [2:0] MC_NORMAL   = 3'h1;
  localparam logic [2:0] MC_STOP     = 3'h2;
  localparam logic [2:0] MC_SLEEP    = 3'h3;
  localparam logic [2:0] MC_RESTART  = 3'h4;
  localparam logic [2:0] MC_FAILSAFE = 3'h5;

  // Shared pin function codes
  localparam logic [1:0] PF_OFF   = 2'h0;
  localparam logic [1:0] PF_FAIL  = 2'h1;
  localparam logic [1:0] PF_WAKE  = 2'h2;
  localparam logic [1:0] PF_DRIVE = 2'h3;

  // Reset values
  localparam logic [1:0]    PIN_FUNC_RST = PF_OFF;
  localparam logic [3:0]    PULL_RST     = 4'h0;
  localparam logic [ST_W-1:0] MASK_RST   = 3'h0;

  typedef enum logic [2:0] {
    MD_INIT, MD_NORMAL, MD_STOP, MD_SLEEP, MD_RESTART, MD_FAILSAFE
  } hvmsc_mode_t;

  typedef struct packed {
    logic up;
    logic down;
  } hvmsc_pull_t;

endpackage
`default_nettype wire

// ### logic/hvmsc_top.sv
// Measurement switch control with its APB register file
`default_nettype none
module hvmsc_top (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  // Device mode and events
  input  wire logic                  fail_safe_req,
  input  wire logic                  other_wake_src,
  input  wire logic                  fail_event,
  output var  logic [2:0]            op_mode_code,
  output var  logic                  irq,
  // Pins and analog switch
  input  wire logic                  hv_sense_input,
  input  wire logic                  fail_or_io_pin_i,
  output var  logic                  fail_or_io_pin_o,
  output var  logic                  fail_or_io_pin_oe,
  output var  logic                  meas_switch_closed,
  output var  hvmsc_pkg::hvmsc_pull_t sense_pull,
  output var  hvmsc_pkg::hvmsc_pull_t pin_pull,
  // Gated pin signals toward the rest of the device
  output var  logic                  sense_to_logic,
  output var  logic                  pin_to_logic,
  output var  logic                  sense_wake_src_en
);

  hvmsc_pkg::hvmsc_mode_t mode;
  hvmsc_pkg::hvmsc_mode_t next_mode;
  logic                   meas_enable;
  logic                   next_meas;
  logic [2:0]             next_code;
  logic [1:0]             pin_func;
  logic                   fail_output_test;
  logic                   pin_out_level;
  logic [3:0]             sense_pull_config;
  logic                   sense_wake_enable;
  logic [hvmsc_pkg::ST_W-1:0] status;
  logic [hvmsc_pkg::ST_W-1:0] irq_mask;
  logic [hvmsc_pkg::ST_W-1:0] st_set;
  logic [hvmsc_pkg::ST_W-1:0] st_clr;
  logic [1:0]             sense_level_status;
  logic [31:0]            rdata;
  logic                   setup;
  logic                   acc;
  logic                   wr;
  logic                   mapped;
  logic                   sel_ctrl;
  logic                   sel_mode;
  logic                   sel_pin;
  logic                   sel_pull;
  logic                   sel_wake;
  logic                   sel_status;
  logic                   sel_mask;
  logic                   sel_level;
  logic [1:0]             pw_func;
  logic [2:0]             pw_mode;
  logic                   meas_refused;
  logic                   pin_write_err;
  logic                   sleep_refused;
  logic                   fs_entry;
  logic                   fo_active;
  logic                   drive_active;

  // Bus phases; a write lands only on the completing access edge
  assign setup   = psel & ~penable;
  assign acc     = psel & penable & pready;
  assign wr      = acc & pwrite;
  assign pw_func = pwdata[hvmsc_pkg::PIN_FUNC_LSB +: 2];
  assign pw_mode = pwdata[hvmsc_pkg::MODE_LSB +: 3];

  // Address decode
  always_comb
  begin
    sel_ctrl   = 1'h0;
    sel_mode   = 1'h0;
    sel_pin    = 1'h0;
    sel_pull   = 1'h0;
    sel_wake   = 1'h0;
    sel_status = 1'h0;
    sel_mask   = 1'h0;
    sel_level  = 1'h0;
    mapped     = 1'h1;
    if (paddr == hvmsc_pkg::ADDR_CTRL)
      sel_ctrl = 1'h1;
    else if (paddr == hvmsc_pkg::ADDR_MODE)
      sel_mode = 1'h1;
    else if (paddr == hvmsc_pkg::ADDR_PIN)
      sel_pin = 1'h1;
    else if (paddr == hvmsc_pkg::ADDR_PULL)
      sel_pull = 1'h1;
    else if (paddr == hvmsc_pkg::ADDR_WAKE)
      sel_wake = 1'h1;
    else if (paddr == hvmsc_pkg::ADDR_STATUS)
      sel_status = 1'h1;
    else if (paddr == hvmsc_pkg::ADDR_MASK)
      sel_mask = 1'h1;
    else if (paddr == hvmsc_pkg::ADDR_LEVEL)
      sel_level = 1'h1;
    else
      mapped = 1'h0;
  end

  // Illegal requests that raise the command error
  assign meas_refused  = wr & sel_ctrl & pwdata[hvmsc_pkg::CTRL_MEAS]
                       & (pin_func != hvmsc_pkg::PF_OFF);
  assign pin_write_err = wr & sel_pin & meas_enable;
  // Sense and pin wake do not count as wake sources while measuring
  assign sleep_refused = wr & sel_mode & ~fail_safe_req
                       & (pw_mode == hvmsc_pkg::MC_SLEEP)
                       & meas_enable & ~other_wake_src
                       & (sense_wake_enable
                          | (pin_func == hvmsc_pkg::PF_WAKE));

  // Enable bit; a refused set leaves it unchanged
  always_comb
  begin
    next_meas = meas_enable;
    if (wr && sel_ctrl && !meas_refused)
      next_meas = pwdata[hvmsc_pkg::CTRL_MEAS];
  end

  // Mode sequencing; fail-safe requests win over commands
  always_comb
  begin
    next_mode = mode;
    if (fail_safe_req)
      next_mode = hvmsc_pkg::MD_FAILSAFE;
    else if (wr && sel_mode)
    begin
      case (pw_mode)
        hvmsc_pkg::MC_NORMAL: next_mode = hvmsc_pkg::MD_NORMAL;
        hvmsc_pkg::MC_STOP:   next_mode = hvmsc_pkg::MD_STOP;
        hvmsc_pkg::MC_SLEEP:
          next_mode = sleep_refused ? hvmsc_pkg::MD_RESTART
                                    : hvmsc_pkg::MD_SLEEP;
        default:              next_mode = mode;
      endcase
    end
  end

  // Mode code seen by the rest of the device
  always_comb
  begin
    case (next_mode)
      hvmsc_pkg::MD_NORMAL:   next_code = hvmsc_pkg::MC_NORMAL;
      hvmsc_pkg::MD_STOP:     next_code = hvmsc_pkg::MC_STOP;
      hvmsc_pkg::MD_SLEEP:    next_code = hvmsc_pkg::MC_SLEEP;
      hvmsc_pkg::MD_RESTART:  next_code = hvmsc_pkg::MC_RESTART;
      hvmsc_pkg::MD_FAILSAFE: next_code = hvmsc_pkg::MC_FAILSAFE;
      default:                next_code = hvmsc_pkg::MC_INIT;
    endcase
  end

  assign fs_entry = (next_mode == hvmsc_pkg::MD_FAILSAFE)
                  & (mode != hvmsc_pkg::MD_FAILSAFE);

  // Mode, enable and switch share one edge so the switch never lags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode               <= hvmsc_pkg::MD_INIT;
      op_mode_code       <= hvmsc_pkg::MC_INIT;
      meas_enable        <= 1'h0;
      meas_switch_closed <= 1'h0;
    end
    else
    begin
      mode               <= next_mode;
      op_mode_code       <= next_code;
      meas_enable        <= next_meas;
      meas_switch_closed <= next_meas
                          & (next_mode == hvmsc_pkg::MD_NORMAL);
    end
  end

  // Pin configuration is always stored, even when it cannot take effect
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_func          <= hvmsc_pkg::PIN_FUNC_RST;
      fail_output_test  <= 1'h0;
      pin_out_level     <= 1'h0;
      sense_pull_config <= hvmsc_pkg::PULL_RST;
    end
    else
    begin
      if (wr && sel_pin)
      begin
        pin_func         <= pw_func;
        fail_output_test <= pwdata[hvmsc_pkg::PIN_TEST];
        pin_out_level    <= pwdata[hvmsc_pkg::PIN_LEVEL];
      end
      if (wr && sel_pull)
        sense_pull_config <=
          pwdata[hvmsc_pkg::PULL_SENSE_LSB +: 4];
    end
  end

  // Wake control; fail-safe entry arms sense wake unless measuring
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sense_wake_enable <= 1'h0;
    else if (fs_entry && !meas_enable)
      sense_wake_enable <= 1'h1;
    else if (wr && sel_wake)
      sense_wake_enable <= pwdata[hvmsc_pkg::WAKE_SENSE];
  end

  // Pin drive: fail output pulls low, drive function follows the level
  assign fo_active    = ~meas_enable & (pin_func == hvmsc_pkg::PF_FAIL);
  assign drive_active = ~meas_enable & (pin_func == hvmsc_pkg::PF_DRIVE);

  // Effective pin behaviour, gated while the switch may carry HV
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fail_or_io_pin_o  <= 1'h0;
      fail_or_io_pin_oe <= 1'h0;
      sense_pull        <= '0;
      pin_pull          <= '0;
      sense_to_logic    <= 1'h0;
      pin_to_logic      <= 1'h0;
      sense_wake_src_en <= 1'h0;
    end
    else
    begin
      fail_or_io_pin_o  <= drive_active & pin_out_level;
      fail_or_io_pin_oe <= (fo_active & (fail_event | fail_output_test))
                         | drive_active;
      sense_pull <= meas_enable ? '0 : hvmsc_pkg::hvmsc_pull_t'(
        sense_pull_config[hvmsc_pkg::PULL_SENSE_LSB +: 2]);
      pin_pull   <= meas_enable ? '0 : hvmsc_pkg::hvmsc_pull_t'(
        sense_pull_config[hvmsc_pkg::PULL_PIN_LSB +: 2]);
      sense_to_logic    <= ~meas_enable & hv_sense_input;
      pin_to_logic      <= ~meas_enable & fail_or_io_pin_i;
      sense_wake_src_en <= ~meas_enable & sense_wake_enable;
    end
  end

  // Level status doubles as the reference for wake edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sense_level_status <= '0;
    else if (!meas_enable)
    begin
      sense_level_status[hvmsc_pkg::LVL_SENSE] <= hv_sense_input;
      sense_level_status[hvmsc_pkg::LVL_PIN]   <= fail_or_io_pin_i;
    end
  end

  // Event sources of the sticky status
  always_comb
  begin
    st_set = '0;
    st_set[hvmsc_pkg::ST_CMD_ERR] = meas_refused | pin_write_err
                                  | sleep_refused;
    st_set[hvmsc_pkg::ST_WAKE_SENSE] = ~meas_enable
      & sense_wake_enable
      & (hv_sense_input != sense_level_status[hvmsc_pkg::LVL_SENSE]);
    st_set[hvmsc_pkg::ST_WAKE_PIN] = ~meas_enable
      & (pin_func == hvmsc_pkg::PF_WAKE)
      & (fail_or_io_pin_i != sense_level_status[hvmsc_pkg::LVL_PIN]);
  end

  assign st_clr = (wr && sel_status) ? pwdata[hvmsc_pkg::ST_W-1:0] : '0;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status <= '0;
    else
      status <= (status & ~st_clr) | st_set;
  end

  // Interrupt mask and level output, one cycle behind the status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask <= hvmsc_pkg::MASK_RST;
      irq      <= 1'h0;
    end
    else
    begin
      if (wr && sel_mask)
        irq_mask <= pwdata[hvmsc_pkg::ST_W-1:0];
      irq <= |(status & irq_mask);
    end
  end

  // Read data mux; reserved bits read as zero
  always_comb
  begin
    rdata = '0;
    if (sel_ctrl)
      rdata[hvmsc_pkg::CTRL_MEAS] = meas_enable;
    else if (sel_mode)
      rdata[hvmsc_pkg::MODE_LSB +: 3] = op_mode_code;
    else if (sel_pin)
    begin
      rdata[hvmsc_pkg::PIN_FUNC_LSB +: 2] = pin_func;
      rdata[hvmsc_pkg::PIN_TEST]          = fail_output_test;
      rdata[hvmsc_pkg::PIN_LEVEL]         = pin_out_level;
    end
    else if (sel_pull)
      rdata[hvmsc_pkg::PULL_SENSE_LSB +: 4] = sense_pull_config;
    else if (sel_wake)
      rdata[hvmsc_pkg::WAKE_SENSE] = sense_wake_enable;
    else if (sel_status)
      rdata[hvmsc_pkg::ST_W-1:0] = status;
    else if (sel_mask)
      rdata[hvmsc_pkg::ST_W-1:0] = irq_mask;
    else if (sel_level)
      rdata[hvmsc_pkg::LVL_SENSE +: 2] = sense_level_status;
  end

  // Answer captured in setup, so every access completes with no wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= pwrite ? '0 : rdata;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_switch_off_idle: assert property (
    !next_meas |=> !meas_switch_closed)
    else $error("switch closed with measurement off");

  a_switch_mode_tie: assert property (
    meas_switch_closed == (meas_enable
      && mode == hvmsc_pkg::MD_NORMAL))
    else $error("switch out of step with mode");

  a_switch_same_cyc: assert property (
    meas_switch_closed && $changed(mode)
    |-> mode == hvmsc_pkg::MD_NORMAL)
    else $error("switch lagged a mode change");

  a_pulls_gated: assert property (
    meas_enable |=> sense_pull == '0 && pin_pull == '0
      && !sense_to_logic && !pin_to_logic)
    else $error("pulls or inputs live while measuring");

  a_pin_cfg_kept: assert property (
    wr && sel_pin && meas_enable |=> pin_func == $past(pw_func)
      && !fail_or_io_pin_oe)
    else $error("pin setting lost or applied");

  a_level_frozen: assert property (
    meas_enable [*2] |-> $stable(sense_level_status)
      && !$rose(status[hvmsc_pkg::ST_WAKE_PIN]))
    else $error("level or wake status moved");

  a_sleep_restart: assert property (
    sleep_refused |=> mode == hvmsc_pkg::MD_RESTART
      && status[hvmsc_pkg::ST_CMD_ERR])
    else $error("sleep not refused into restart");

  a_pin_func_off: assert property (
    meas_enable |=> !fail_or_io_pin_oe && !fail_or_io_pin_o)
    else $error("pin function active while measuring");

  a_pin_wr_err: assert property (
    pin_write_err |=> status[hvmsc_pkg::ST_CMD_ERR])
    else $error("pin write did not flag error");

  a_enable_refused: assert property (
    meas_refused && !meas_enable |=> !meas_enable
      && status[hvmsc_pkg::ST_CMD_ERR])
    else $error("enable accepted with pin in use");

  a_wake_ignored: assert property (
    wr && sel_wake && meas_enable |=> !sense_wake_src_en
      ##1 !sense_wake_src_en)
    else $error("sense wake honoured while measuring");

  a_failsafe_entry: assert property (
    fs_entry |=> !meas_switch_closed && (meas_enable
      ? $past(meas_enable) : sense_wake_enable))
    else $error("fail-safe entry handled wrong");

endmodule // hvmsc_top
`default_nettype wire
